// ---- hdl/clock_gen_regs.vh ----
/*
   Constants for the loop clock generator and supervisor: register
   offsets, field positions, reset values and timing counts.
   Assumes a 32-bit classic Wishbone slave on a 25 MHz system clock.
*/
// Summary of operation
// - Reference divides oscillator by field plus one
// - Feedback divides by twice the multiplier plus two
// - Bus clock is selected source clock halved
// - Core twice bus; bus drives pin
// - Acquisition mode holds fine flag cleared
// - Auto mode: fine flag follows tolerances
// - Auto select lets detector switch modes
// - Read-only in-tolerance lock flag
// - Lock flag toggle requests interrupt if enabled
// - Manual mode: software writes coarse bit
// - Power-down ignored while loop selected
// - Source switch freezes clocks, bounded time
// - Self clock uses loop at minimum
// - Monitor fail: self clock or reset
// - Monitor enable gates failure detection
// - Quality check starts on listed events
// - Window 50000 loop cycles, 4096 edges
// - Quality check runs alongside fail handling
// - Pending check forces loop, regulator on
// - Watchdog off at reset, seven rates
// - 55 then AA restarts watchdog period
// - Rate field selects timeout, nonzero starts
// - Other service value causes watchdog reset
// - Windowed mode: early write resets
`ifndef CLOCK_GEN_REGS_VH
`define CLOCK_GEN_REGS_VH

// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define OFS_REF_DIV     6'h00
`define OFS_MULT        6'h04
`define OFS_FLAGS       6'h08
`define OFS_CTRL        6'h0c
`define OFS_WD_CFG      6'h10
`define OFS_WD_SERVICE  6'h14

// -------------------------------------------------------------
// Field positions
// -------------------------------------------------------------
`define FLG_LOCK_CHG    0
`define FLG_LOCK        1
`define FLG_TRACK       2
`define FLG_SELF_CLK    3
`define CTL_IRQ_EN      0
`define CTL_AUTO        1
`define CTL_ACQ         2
`define CTL_PWR_ON      3
`define CTL_MON_EN      4
`define CTL_SELF_EN     5
`define CTL_LOOP_SEL    6
`define WD_WINDOWED     7

// -------------------------------------------------------------
// Reset values and codes
// -------------------------------------------------------------
`define CTRL_RESET      7'h3e
`define SVC_ARM         8'h55
`define SVC_RESTART     8'haa

// -------------------------------------------------------------
// Timing counts
// -------------------------------------------------------------
`define MONITOR_CYCLES  8'h40
`define CHECK_WINDOW    50000
`define OSC_OK_EDGES    4096
`define SWITCH_EDGES    3'h4

`endif

// ---- hdl/loop_clock_gen.v ----
/*
   Loop clock generator and supervisor: dividers, bus and core clocks,
   lock status, source switch, clock monitor, quality check, watchdog.
   Assumes oscillator and loop clocks arrive as pins oversampled by
   clk_sys, so both must stay well below half of 25 MHz.
*/
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_regs.vh"
module loop_clock_gen #(
   parameter CHECK_WINDOW = `CHECK_WINDOW,
   parameter OSC_OK_EDGES = `OSC_OK_EDGES
) (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        osc_clock,
   input  wire        loop_output_clock,
   input  wire        track_in_tol,
   input  wire        lock_in_tol,
   input  wire        por_event,
   input  wire        lvr_event,
   input  wire        stop_wake_event,
   output reg         reference_clock,
   output reg         feedback_clock,
   output reg         core_clock,
   output reg         external_bus_clock_pin,
   output reg         acq_mode,
   output reg         loop_power,
   output reg         voltage_regulator,
   output reg         clocks_frozen,
   output reg         tolerance_irq,
   output reg         monitor_reset,
   output reg         watchdog_reset,
   output reg         self_clock_mode
);
   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   localparam SW_IDLE = 2'b00; // Source switch states
   localparam SW_OSC  = 2'b01;
   localparam SW_LOOP = 2'b10;
   reg  [3:0]  s1_r, s2_r, s3_r, clean_r; // Pin synchronisers, agreed levels
   wire [3:0]  clean_nxt;                 // Next agreed levels
   wire        osc_rise, loop_rise;       // Synced rising edges
   reg  [3:0]  ref_div_r, ref_cnt_r;      // Reference divider field and count
   reg  [5:0]  mult_r;                    // Multiplier field
   reg  [6:0]  ctrl_r;                    // Control bits
   reg  [2:0]  wd_rate_r, sw_cnt_r;       // Watchdog rate, edges seen in switch
   reg         wd_win_r, wd_cfg_done_r;   // Windowed watchdog, config written
   reg         wd_armed_r, lock_chg_r;    // 55 seen, sticky lock toggle
   reg  [6:0]  fb_cnt_r;                  // Feedback divider count
   reg  [1:0]  sw_state_r;                // Source switch state
   reg         src_loop_r, qc_busy_r;     // Source is loop, check pending
   reg  [7:0]  mon_cnt_r;                 // Cycles without osc edge
   reg  [15:0] qc_win_r;                  // Window loop cycles
   reg  [12:0] qc_edges_r;                // Osc edges in window
   reg  [24:0] wd_cnt_r;                  // Watchdog count
   wire        req, wr, wd_on;            // Request, write landing, watchdog on
   wire [24:0] wd_limit;                  // Timeout in osc cycles
   wire        mon_fail, want_loop;       // Monitor failure, requested source
   wire        lock_flag, track_flag;     // Synced lock flag, fine mode flag
   // Timeout length for a rate code
   function [24:0] wd_period;
      input [2:0] rate;
      begin
         case (rate)
            3'h1:    wd_period = 25'h0004000;
            3'h2:    wd_period = 25'h0010000;
            3'h3:    wd_period = 25'h0040000;
            3'h4:    wd_period = 25'h0100000;
            3'h5:    wd_period = 25'h0400000;
            3'h6:    wd_period = 25'h0800000;
            3'h7:    wd_period = 25'h1000000;
            default: wd_period = 25'h0000000;
         endcase
      end
   endfunction
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   // A bit only moves once the second and third stages agree
   assign clean_nxt = (s3_r & ~(s2_r ^ s3_r)) | (clean_r & (s2_r ^ s3_r));
   assign osc_rise  = clean_nxt[0] & ~clean_r[0];
   assign loop_rise = clean_nxt[1] & ~clean_r[1];

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_r    <= 4'h0;
         s2_r    <= 4'h0;
         s3_r    <= 4'h0;
         clean_r <= 4'h0;
      end else begin
         s1_r    <= {lock_in_tol, track_in_tol, loop_output_clock, osc_clock};
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         clean_r <= clean_nxt;
      end
   end
   // Bus decode and status flags
   assign req       = wb_cyc_i & wb_stb_i;
   assign wr        = req & wb_we_i & wb_ack_o;
   assign wd_on     = (wd_rate_r != 3'h0);
   assign wd_limit  = wd_period(wd_rate_r);
   assign lock_flag = clean_r[3];
   // Manual mode: fine flag is the inverse of the coarse bit
   assign track_flag = ctrl_r[`CTL_AUTO] ? clean_r[2] : ~ctrl_r[`CTL_ACQ];
   // No failure while disabled or while edges keep coming
   assign mon_fail  = ctrl_r[`CTL_MON_EN] & (mon_cnt_r == `MONITOR_CYCLES);
   assign want_loop = ctrl_r[`CTL_LOOP_SEL] | self_clock_mode;
   // -------------------------------------------------------------
   // Wishbone slave and register writes
   // -------------------------------------------------------------
   // Ack one cycle after the request; writes land on the ack edge
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h00000000;
         ref_div_r     <= 4'h0;
         mult_r        <= 6'h00;
         ctrl_r        <= `CTRL_RESET;
         wd_rate_r     <= 3'h0;
         wd_win_r      <= 1'b0;
         wd_cfg_done_r <= 1'b0;
         lock_chg_r    <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o & ~wb_we_i) begin
            case (wb_adr_i)
               `OFS_REF_DIV: wb_dat_o <= {28'h0000000, ref_div_r};
               `OFS_MULT:    wb_dat_o <= {26'h0000000, mult_r};
               `OFS_FLAGS:   wb_dat_o <= {28'h0000000, self_clock_mode,
                                          track_flag, lock_flag, lock_chg_r};
               `OFS_CTRL:    wb_dat_o <= {25'h0000000, ctrl_r};
               `OFS_WD_CFG:  wb_dat_o <= {24'h000000, wd_win_r, 4'h0, wd_rate_r};
               default:      wb_dat_o <= 32'h00000000; // Unmapped reads zero
            endcase
         end
         if (wr && wb_adr_i == `OFS_REF_DIV && wb_sel_i[0]) begin
            ref_div_r <= wb_dat_i[3:0];
         end
         if (wr && wb_adr_i == `OFS_MULT && wb_sel_i[0]) begin
            mult_r <= wb_dat_i[5:0];
         end
         if (wr && wb_adr_i == `OFS_CTRL && wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[6:0];
            // Power-down refused while the loop select bit is set
            if (ctrl_r[`CTL_LOOP_SEL] & ~wb_dat_i[`CTL_PWR_ON]) begin
               ctrl_r[`CTL_PWR_ON] <= 1'b1;
            end
         end else if (mon_fail & ctrl_r[`CTL_SELF_EN]) begin
            ctrl_r[`CTL_LOOP_SEL] <= 1'b0;
         end
         // Rate and window bits may be written only once
         if (wr && wb_adr_i == `OFS_WD_CFG && wb_sel_i[0] && !wd_cfg_done_r) begin
            wd_rate_r     <= wb_dat_i[2:0];
            wd_win_r      <= wb_dat_i[`WD_WINDOWED];
            wd_cfg_done_r <= 1'b1;
         end
         // Toggle sets win over a write-one clear in the same cycle
         if (clean_nxt[3] != clean_r[3]) begin
            lock_chg_r <= 1'b1;
         end else if (wr && wb_adr_i == `OFS_FLAGS && wb_sel_i[0] &&
                      wb_dat_i[`FLG_LOCK_CHG]) begin
            lock_chg_r <= 1'b0;
         end
      end
   end
   // -------------------------------------------------------------
   // Reference and feedback dividers
   // -------------------------------------------------------------
   // Each divider emits a one-cycle pulse per divided period
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ref_cnt_r       <= 4'h0;
         fb_cnt_r        <= 7'h00;
         reference_clock <= 1'b0;
         feedback_clock  <= 1'b0;
      end else begin
         reference_clock <= 1'b0;
         feedback_clock  <= 1'b0;
         if (osc_rise) begin
            if (ref_cnt_r >= ref_div_r) begin
               ref_cnt_r       <= 4'h0;
               reference_clock <= 1'b1;
            end else begin
               ref_cnt_r <= ref_cnt_r + 4'h1;
            end
         end
         if (loop_rise) begin
            if (fb_cnt_r >= {mult_r, 1'b1}) begin
               fb_cnt_r       <= 7'h00;
               feedback_clock <= 1'b1;
            end else begin
               fb_cnt_r <= fb_cnt_r + 7'h01;
            end
         end
      end
   end
   // -------------------------------------------------------------
   // Source switch and clock outputs
   // -------------------------------------------------------------
   // Freeze for up to 4 osc then 4 loop edges when source changes
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sw_state_r             <= SW_IDLE;
         sw_cnt_r               <= 3'h0;
         src_loop_r             <= 1'b0;
         clocks_frozen          <= 1'b0;
         core_clock             <= 1'b0;
         external_bus_clock_pin <= 1'b0;
      end else begin
         case (sw_state_r)
            SW_IDLE: begin
               if (want_loop != src_loop_r) begin
                  sw_state_r    <= SW_OSC;
                  sw_cnt_r      <= 3'h0;
                  clocks_frozen <= 1'b1;
               end
            end
            SW_OSC: begin
               if (osc_rise) begin
                  sw_cnt_r <= sw_cnt_r + 3'h1;
               end
               // A dead crystal gives no edges, so self clock skips them
               if (sw_cnt_r == `SWITCH_EDGES || self_clock_mode) begin
                  sw_state_r <= SW_LOOP;
                  sw_cnt_r   <= 3'h0;
               end
            end
            SW_LOOP: begin
               if (loop_rise) begin
                  sw_cnt_r <= sw_cnt_r + 3'h1;
               end
               if (sw_cnt_r == `SWITCH_EDGES) begin
                  sw_state_r    <= SW_IDLE;
                  src_loop_r    <= want_loop;
                  clocks_frozen <= 1'b0;
               end
            end
            default: begin
               sw_state_r <= SW_IDLE;
            end
         endcase
         // Core follows the source; bus is core halved, so 2:1
         if (!clocks_frozen) begin
            core_clock <= src_loop_r ? clean_r[1] : clean_r[0];
            if (src_loop_r ? loop_rise : osc_rise) begin
               external_bus_clock_pin <= ~external_bus_clock_pin;
            end
         end
      end
   end
   // -------------------------------------------------------------
   // Filter mode, power and interrupt outputs
   // -------------------------------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         acq_mode          <= 1'b1;
         loop_power        <= 1'b1;
         voltage_regulator <= 1'b1;
         tolerance_irq     <= 1'b0;
      end else begin
         // Auto: detector picks mode; manual: coarse bit does
         acq_mode <= ctrl_r[`CTL_AUTO] ? ~clean_r[2] : ctrl_r[`CTL_ACQ];
         loop_power        <= ctrl_r[`CTL_PWR_ON] | qc_busy_r;
         voltage_regulator <= qc_busy_r;
         tolerance_irq     <= lock_chg_r & ctrl_r[`CTL_IRQ_EN];
      end
   end
   // -------------------------------------------------------------
   // Clock monitor, self clock mode and quality checker
   // -------------------------------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mon_cnt_r       <= 8'h00;
         monitor_reset   <= 1'b0;
         self_clock_mode <= 1'b0;
         qc_busy_r       <= 1'b1; // Power-on starts a check
         qc_win_r        <= 16'h0000;
         qc_edges_r      <= 13'h0000;
      end else begin
         monitor_reset <= 1'b0;
         if (osc_rise | ~ctrl_r[`CTL_MON_EN] | mon_fail) begin
            mon_cnt_r <= 8'h00;
         end else begin
            mon_cnt_r <= mon_cnt_r + 8'h01;
         end
         if (mon_fail) begin
            if (ctrl_r[`CTL_SELF_EN]) begin
               self_clock_mode <= 1'b1;
            end else begin
               monitor_reset <= 1'b1;
            end
         end
         // Check keeps running whatever the fail handling does
         if (por_event | lvr_event | stop_wake_event | mon_fail) begin
            qc_busy_r  <= 1'b1;
            qc_win_r   <= 16'h0000;
            qc_edges_r <= 13'h0000;
         end else if (qc_busy_r) begin
            if (qc_edges_r + {12'h000, osc_rise} >= OSC_OK_EDGES[12:0]) begin
               qc_busy_r       <= 1'b0;
               self_clock_mode <= 1'b0;
            end else if (loop_rise && qc_win_r + 16'h0001 >= CHECK_WINDOW[15:0]) begin
               qc_win_r   <= 16'h0000;
               qc_edges_r <= 13'h0000;
            end else begin
               qc_win_r   <= qc_win_r + {15'h0000, loop_rise};
               qc_edges_r <= qc_edges_r + {12'h000, osc_rise};
            end
         end
      end
   end
   // -------------------------------------------------------------
   // Watchdog
   // -------------------------------------------------------------
   // Counts oscillator edges; service writes restart or reset
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wd_cnt_r       <= 25'h0000000;
         wd_armed_r     <= 1'b0;
         watchdog_reset <= 1'b0;
      end else begin
         watchdog_reset <= 1'b0;
         if (!wd_on) begin
            wd_cnt_r   <= 25'h0000000;
            wd_armed_r <= 1'b0;
         end else if (wr && wb_adr_i == `OFS_WD_SERVICE && wb_sel_i[0]) begin
            // Early write in windowed mode: first three quarters
            if (wd_win_r && wd_cnt_r < wd_limit - {2'b00, wd_limit[24:2]}) begin
               watchdog_reset <= 1'b1;
               wd_cnt_r       <= 25'h0000000;
               wd_armed_r     <= 1'b0;
            end else if (wb_dat_i[7:0] == `SVC_ARM) begin
               wd_armed_r <= 1'b1;
            end else if (wb_dat_i[7:0] == `SVC_RESTART) begin
               if (wd_armed_r) begin
                  wd_cnt_r <= 25'h0000000;
               end
               wd_armed_r <= 1'b0;
            end else begin
               watchdog_reset <= 1'b1;
               wd_cnt_r       <= 25'h0000000;
               wd_armed_r     <= 1'b0;
            end
         end else if (osc_rise) begin
            if (wd_cnt_r + 25'h0000001 >= wd_limit) begin
               watchdog_reset <= 1'b1;
               wd_cnt_r       <= 25'h0000000;
               wd_armed_r     <= 1'b0;
            end else begin
               wd_cnt_r <= wd_cnt_r + 25'h0000001;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/loop_clock_gen_checker.sv ----
/*
   Port-level checker for the loop clock generator.
   Assumes binding onto loop_clock_gen; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_regs.vh"
module loop_clock_gen_checker (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic        osc_clock,
   input wire logic        lock_in_tol,
   input wire logic        reference_clock,
   input wire logic        feedback_clock,
   input wire logic        core_clock,
   input wire logic        external_bus_clock_pin,
   input wire logic        loop_power,
   input wire logic        voltage_regulator,
   input wire logic        clocks_frozen,
   input wire logic        tolerance_irq,
   input wire logic        monitor_reset,
   input wire logic        watchdog_reset,
   input wire logic        self_clock_mode
);
// ---------------------------------------------
// Helper state
// ---------------------------------------------
logic [7:0] idle_r;    // Cycles since last oscillator rise, saturating
logic [3:0] lk_r;      // Cycles since lock input changed, saturating
logic       osc_q_r;   // Previous oscillator sample
logic       lock_q_r;  // Previous lock input sample
logic       wd_on_r;   // A nonzero rate has been written
// Counters saturate so a long idle never wraps into a false pass
always @(posedge clk_sys or posedge reset) begin
   if (reset) begin
      {idle_r, lk_r, osc_q_r, lock_q_r, wd_on_r} <= {8'h00, 4'hf, 3'h0};
   end else begin
      osc_q_r  <= osc_clock;
      lock_q_r <= lock_in_tol;
      idle_r   <= (osc_clock && !osc_q_r) ? 8'h00 : idle_r + {7'h0, idle_r != 8'hff};
      lk_r     <= (lock_in_tol != lock_q_r) ? 4'h0 : lk_r + {3'h0, lk_r != 4'hf};
      if (wb_ack_o && wb_we_i && wb_adr_i == `OFS_WD_CFG && wb_dat_i[2:0] != 3'h0) begin
         wd_on_r <= 1'b1;
      end
   end
end
// ---------------------------------------------
// Properties
// ---------------------------------------------
default clocking cb @(posedge clk_sys); endclocking
default disable iff (reset);
property p_ref_pulse; reference_clock |=> !reference_clock; endproperty
a_ref_pulse: assert property (p_ref_pulse) else $error("reference pulse too long");
property p_fb_pulse; feedback_clock |=> !feedback_clock; endproperty
a_fb_pulse: assert property (p_fb_pulse) else $error("feedback pulse too long");
property p_frz_hold;
   clocks_frozen && $past(clocks_frozen) |-> $stable(core_clock) && $stable(external_bus_clock_pin);
endproperty
a_frz_hold: assert property (p_frz_hold) else $error("clock moved while frozen");
property p_frz_end; $rose(clocks_frozen) |-> ##[1:400] !clocks_frozen; endproperty
a_frz_end: assert property (p_frz_end) else $error("source switch too long");
property p_voltage_regulator_loop; voltage_regulator |-> loop_power; endproperty
a_voltage_regulator_loop: assert property (p_voltage_regulator_loop) else $error("regulator on, loop off");
property p_irq_cause; $rose(tolerance_irq) |-> lk_r <= 4'h8; endproperty
a_irq_cause: assert property (p_irq_cause) else $error("irq without lock change");
property p_mon_idle; monitor_reset |-> idle_r >= 8'h3c; endproperty
a_mon_idle: assert property (p_mon_idle) else $error("monitor reset with clock");
property p_self_idle; $rose(self_clock_mode) |-> idle_r >= 8'h3c; endproperty
a_self_idle: assert property (p_self_idle) else $error("self clock with clock");
property p_wd_on; watchdog_reset |-> wd_on_r; endproperty
a_wd_on: assert property (p_wd_on) else $error("watchdog reset while off");
cover property ($rose(self_clock_mode));
cover property (monitor_reset);
cover property (watchdog_reset);
endmodule
`default_nettype wire

// ---- verif/osc_loop_model.sv ----
/*
   Behavioural crystal oscillator and loop oscillator.
   Assumes the bench starts and stops the crystal through osc_run.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_loop_model (
   input  wire logic osc_run,           // Crystal running when high
   output var  logic osc_clock,         // Oscillator pin, 3.125 MHz
   output var  logic loop_output_clock  // Loop output, free running
);
// A failed crystal stops low; offset keeps edges off the system clock
initial begin
   osc_clock = 1'b0;
   #7;
   forever #160 osc_clock = osc_run ? ~osc_clock : 1'b0;
end
// Loop keeps running at its floor rate even without a reference
initial begin
   loop_output_clock = 1'b0;
   #3;
   forever #120 loop_output_clock = ~loop_output_clock;
end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
/*
   Self-checking bench for loop_clock_gen over classic Wishbone.
   Assumes osc_loop_model drives the clock pins; short check counts.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_regs.vh"
module testbench;
// ---------------------------------------------
// Signals, design, model
// ---------------------------------------------
logic        clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, osc_run;
logic        track_in_tol, lock_in_tol, por_event, lvr_event, stop_wake_event;
logic [5:0]  wb_adr_i;
logic [3:0]  wb_sel_i;
logic [31:0] wb_dat_i, wb_dat_o, rd;
logic        wb_ack_o, osc_clock, loop_output_clock, reference_clock, feedback_clock;
logic        core_clock, external_bus_clock_pin, acq_mode, loop_power, voltage_regulator;
logic        clocks_frozen, tolerance_irq, monitor_reset, watchdog_reset, self_clock_mode;
int          errors, compares, oc, lc, nmr, nwr, c;
loop_clock_gen #(.CHECK_WINDOW(200), .OSC_OK_EDGES(16)) dut_u (.*);
osc_loop_model pm_u (.osc_run(osc_run), .osc_clock(osc_clock),
                     .loop_output_clock(loop_output_clock));
initial begin
   clk_sys = 1'b0;
   forever #20 clk_sys = ~clk_sys;
end
// Edge and pulse counters seen by the comparisons
always @(posedge osc_clock) oc++;
always @(posedge loop_output_clock) lc++;
always @(posedge clk_sys) if (monitor_reset === 1'b1) nmr++;
always @(posedge clk_sys) if (watchdog_reset === 1'b1) nwr++;
// ---------------------------------------------
// Tasks
// ---------------------------------------------
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   compares++;
   if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
   end
endtask
// One classic cycle; holds everything until ack is sampled high
task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
   @(posedge clk_sys);
   {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hf, d};
   do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
   rd = wb_dat_o;
   {wb_cyc_i, wb_stb_i} <= 2'h0;
endtask
task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
   wb(1'b0, a, 32'h0);
   chk(rd, e);
endtask
function automatic logic sig(int s);
   return s == 0 ? reference_clock : s == 1 ? feedback_clock : external_bus_clock_pin;
endfunction
task automatic rise_of(int s);
   int n;
   n = 0;
   while (sig(s) !== 1'b0 && n < 3000) begin @(posedge clk_sys); n++; end
   while (sig(s) !== 1'b1 && n < 6000) begin @(posedge clk_sys); n++; end
endtask
// Source edges between two output rises; first rise only aligns
task automatic gap(int s, int e);
   int b;
   rise_of(s);
   rise_of(s);
   b = (s == 1 || s == 3) ? lc : oc;
   rise_of(s);
   chk(((s == 1 || s == 3) ? lc : oc) - b, e);
endtask
task automatic settle();
   int n;
   n = 0;
   repeat (2) @(posedge clk_sys);
   while (clocks_frozen === 1'b1 && n < 400) begin @(posedge clk_sys); n++; end
endtask
task automatic stop_test();
   $display("errors=%0d compares=%0d", errors, compares);
   if (errors == 0 && compares > 0) $display("*** PASS ***");
   else $display("*** FAIL ***");
   $finish;
endtask
// ---------------------------------------------
// Tests
// ---------------------------------------------
initial begin
   {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, track_in_tol, lock_in_tol} = '0;
   {por_event, lvr_event, stop_wake_event, errors, compares, oc, lc, nmr, nwr} = '0;
   {reset, osc_run, wb_sel_i} = {2'h3, 4'hf};
   repeat (4) @(posedge clk_sys);
   reset <= 1'b0;
   rdchk(`OFS_CTRL, {25'h0, `CTRL_RESET});
   rdchk(6'h18, 32'h0);
   repeat (300) @(posedge clk_sys);
   chk(voltage_regulator, 1'b0);
   // Each start event forces a new check
   for (int i = 0; i < 3; i++) begin
      {por_event, lvr_event, stop_wake_event} <= 3'h4 >> i;
      @(posedge clk_sys);
      {por_event, lvr_event, stop_wake_event} <= 3'h0;
      repeat (3) @(posedge clk_sys);
      chk({voltage_regulator, loop_power}, 2'h3);
      repeat (300) @(posedge clk_sys);
   end
   wb(1'b1, `OFS_REF_DIV, 32'h0);
   gap(0, 1);
   wb(1'b1, `OFS_REF_DIV, 32'hf);
   gap(0, 16);
   wb(1'b1, `OFS_MULT, 32'h3f);
   gap(1, 128);
   wb(1'b1, `OFS_MULT, 32'h0);
   gap(1, 2);
   gap(2, 2);
   // Lock toggles in both directions raise the request
   wb(1'b1, `OFS_CTRL, 32'h3f);
   {lock_in_tol, track_in_tol} <= 2'h3;
   repeat (10) @(posedge clk_sys);
   chk(tolerance_irq, 1'b1);
   rdchk(`OFS_FLAGS, 32'h7);
   wb(1'b1, `OFS_FLAGS, 32'h1);
   repeat (3) @(posedge clk_sys);
   chk(tolerance_irq, 1'b0);
   lock_in_tol <= 1'b0;
   repeat (10) @(posedge clk_sys);
   chk(tolerance_irq, 1'b1);
   wb(1'b1, `OFS_FLAGS, 32'h1);
   // Manual filter control, acquisition first, then tracking
   wb(1'b1, `OFS_CTRL, 32'h3c);
   repeat (6) @(posedge clk_sys);
   chk(acq_mode, 1'b1);
   rdchk(`OFS_FLAGS, 32'h0);
   wb(1'b1, `OFS_CTRL, 32'h38);
   repeat (6) @(posedge clk_sys);
   chk(acq_mode, 1'b0);
   wb(1'b1, `OFS_CTRL, 32'h78);
   repeat (2) @(posedge clk_sys);
   chk(clocks_frozen, 1'b1);
   settle();
   gap(3, 2);
   wb(1'b1, `OFS_CTRL, 32'h70);
   rdchk(`OFS_CTRL, 32'h78);
   chk(loop_power, 1'b1);
   wb(1'b1, `OFS_CTRL, 32'h38);
   settle();
   // Crystal loss with self clock enabled, then recovery
   osc_run <= 1'b0;
   repeat (200) @(posedge clk_sys);
   chk({self_clock_mode, voltage_regulator, 30'(nmr)}, {2'h3, 30'h0});
   osc_run <= 1'b1;
   repeat (600) @(posedge clk_sys);
   chk(self_clock_mode, 1'b0);
   wb(1'b1, `OFS_CTRL, 32'h18);
   osc_run <= 1'b0;
   repeat (150) @(posedge clk_sys);
   chk(nmr > 0, 1'b1);
   osc_run <= 1'b1;
   repeat (600) @(posedge clk_sys);
   wb(1'b1, `OFS_CTRL, 32'h08);
   c = nmr;
   osc_run <= 1'b0;
   repeat (150) @(posedge clk_sys);
   chk(nmr - c, 0);
   osc_run <= 1'b1;
   // Watchdog off until a rate is set, then served and abused
   wb(1'b1, `OFS_WD_SERVICE, 32'h12);
   wb(1'b1, `OFS_WD_CFG, 32'h1);
   wb(1'b1, `OFS_WD_SERVICE, {24'h0, `SVC_ARM});
   wb(1'b1, `OFS_WD_SERVICE, {24'h0, `SVC_RESTART});
   repeat (4) @(posedge clk_sys);
   chk(nwr, 0);
   wb(1'b1, `OFS_WD_SERVICE, 32'h12);
   repeat (4) @(posedge clk_sys);
   chk(nwr, 1);
   stop_test();
end
// Hang guard
initial begin
   repeat (40000) @(posedge clk_sys);
   errors++;
   stop_test();
end
endmodule
bind loop_clock_gen loop_clock_gen_checker chk_u (.*);
`default_nettype wire
